//--- irsl_pkg.sv
// Operation
// RQ1: Accept infrared receive data or host serial data, never both at once.
// RQ2: Hold clear-to-send high while infrared data is sent or received.
// RQ3: Host must not send serial bytes while clear-to-send is high.
// RQ4: Serial FIFO keeps two bytes while clear-to-send is high; more are dropped.
// RQ5: Connected mode checks each packet and keeps exchanging packets periodically.
// RQ6: On close-link command, confirm and return to disconnect state.
// RQ7: Ten seconds without a frame while connected returns to disconnect state.
// RQ8: Answer discovery polling only in timeslot two, claiming it.
// RQ9: After claiming, ignore remaining polls and the broadcast identification frame.
// RQ10: Primary spaces polling commands roughly seventy milliseconds apart.
// RQ11: Answer link setup with own parameters using the given connection address.
// RQ12: Confirm information channel, answer each query, then confirm data channel.
// RQ13: Drive carrier detect low once the link reaches normal response mode.
// RQ14: Assert data-set-ready only after power-up and initialization complete.
// RQ15: Only data crosses the link; modem signals are generated locally.
// RQ16: Separate 64-byte buffers for infrared data and serial data.
// RQ17: Once an infrared packet begins, serial buffer is unavailable until handled.
// RQ18: User data goes in blocks of at most 64 bytes plus 8 protocol bytes.
// RQ19: Wait the negotiated turnaround latency, commonly 1 ms, before sending.
// RQ20: Leave at least one bit time between received and transmitted bytes.
// RQ21: Infrared port starts at 9600 baud, changes only to the negotiated rate.
// RQ22: Infrared rate is independent of the serial rate set by rate-select pins.
// RQ23: In disconnect and discovery, answer the Primary alone and hold clear-to-send high.
package irsl_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int FALLBACK_S = 10;
	localparam int TURNAROUND_US = 1000;
	localparam longint FALLBACK_CYCLES = longint'(FALLBACK_S) * CLK_HZ;
	localparam int TURNAROUND_CYCLES = TURNAROUND_US * (CLK_HZ / 1_000_000);
	localparam int BUF_DEPTH = 64;
	localparam int FRAME_OVERHEAD = 8;
	localparam int UART_FIFO_DEPTH = 2;
	localparam logic [2:0] CLAIM_SLOT = 3'h2;
	localparam int INIT_CYCLES = 16;
	localparam logic [2:0] IR_RATE_DEFAULT = 3'h0;
	typedef enum logic [3:0]
	{
		FR_NONE,
		FR_XID,
		FR_BCAST_ID,
		FR_SNRM,
		FR_OPEN_IAS,
		FR_IAS_QUERY,
		FR_OPEN_DATA,
		FR_DATA,
		FR_DISC
	} irsl_frame_t;
	typedef enum logic [3:0]
	{
		RSP_NONE,
		RSP_XID,
		RSP_UA_PARAMS,
		RSP_CONFIRM_IAS,
		RSP_IAS_ANSWER,
		RSP_CONFIRM_DATA,
		RSP_DATA,
		RSP_CONFIRM_CLOSE
	} irsl_resp_t;
	typedef enum
	{
		ST_INIT,
		ST_NDM,
		ST_CLAIMED,
		ST_DISCOVERY,
		ST_IAS,
		ST_NRM
	} irsl_state_t;
endpackage : irsl_pkg

//--- irsl_link_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module irsl_link_ctrl #(
	parameter longint FALLBACK_CNT   = irsl_pkg::FALLBACK_CYCLES,
	parameter int     TURNAROUND_CNT = irsl_pkg::TURNAROUND_CYCLES,
	parameter int     BIT_TIME_CNT   = 26042
) (
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  frame_valid_in,
	input  wire irsl_pkg::irsl_frame_t frame_kind_in,
	input  wire logic                  frame_crc_ok_in,
	input  wire logic [2:0]            frame_slot_in,
	input  wire logic [7:0]            frame_addr_in,
	input  wire logic [2:0]            frame_rate_in,
	input  wire logic                  ir_rx_active_in,
	input  wire logic                  ir_tx_active_in,
	input  wire logic                  ir_byte_in,
	input  wire logic [7:0]            ir_byte_data_in,
	input  wire logic                  ir_buf_pop_in,
	input  wire logic                  uart_byte_in,
	input  wire logic [7:0]            uart_byte_data_in,
	input  wire logic [1:0]            uart_rate_select_in,
	input  wire logic                  tx_done_in,
	output logic                       resp_valid_out,
	output irsl_pkg::irsl_resp_t       resp_kind_out,
	output logic [7:0]                 resp_addr_out,
	output logic [6:0]                 resp_len_out,
	output logic [2:0]                 ir_rate_out,
	output logic [1:0]                 uart_rate_out,
	output logic                       cd_n_out,
	output logic                       dsr_n_out,
	output logic                       cts_n_out,
	output logic                       connected_out,
	output logic [6:0]                 ir_buf_level_out,
	output logic [6:0]                 ser_buf_level_out,
	output logic [7:0]                 ir_buf_head_out,
	output logic                       uart_drop_out
);
	import irsl_pkg::*;

	// The idle counter is 40 bits wide, so a longer fallback count cannot be served.
	if (FALLBACK_CNT < 1 || FALLBACK_CNT > 64'sh0000_00FF_FFFF_FFFF
		|| TURNAROUND_CNT < 1 || BIT_TIME_CNT < 1)
	begin : g_bad_counts
		$error("irsl_link_ctrl: timing counts out of range");
	end

	logic              rst_s1_reg;
	logic              rst_s2_reg;
	irsl_state_t       state_reg;
	logic [4:0]        init_cnt_reg;
	logic [39:0]       idle_cnt_reg;
	logic [31:0]       turn_cnt_reg;
	logic              pending_reg;
	irsl_resp_t        pending_kind_reg;
	logic [7:0]        conn_addr_reg;
	logic [2:0]        nego_rate_reg;
	logic [2:0]        ir_rate_reg;
	logic              ir_busy_reg;
	logic              cts_n_reg;
	logic [1:0]        fifo_cnt_reg;
	logic [7:0]        ir_buf_mem [BUF_DEPTH];
	logic [5:0]        ir_wr_reg;
	logic [5:0]        ir_rd_reg;
	logic [6:0]        ir_lvl_reg;
	logic [7:0]        ser_buf_mem [BUF_DEPTH];
	logic [5:0]        ser_wr_reg;
	logic [6:0]        ser_lvl_reg;
	logic              drop_reg;
	logic              rst_n;
	logic              good_frame;
	logic              ir_side_busy;
	logic              ser_accept;
	logic              ir_push;
	logic              ir_pop;

	assign rst_n        = rst_s2_reg;
	assign good_frame   = frame_valid_in && frame_crc_ok_in; // RQ5
	// Infrared traffic, a busy packet or any link phase other than data mode owns the device.
	assign ir_side_busy = ir_rx_active_in || ir_tx_active_in || ir_busy_reg
		|| state_reg != ST_NRM; // RQ1 RQ2 RQ23
	assign ser_accept   = uart_byte_in && ser_lvl_reg < 7'(BUF_DEPTH)
		&& (!cts_n_reg || fifo_cnt_reg < 2'(UART_FIFO_DEPTH)); // RQ4
	assign ir_push      = ir_byte_in && ir_lvl_reg < 7'(BUF_DEPTH); // RQ16
	assign ir_pop       = ir_buf_pop_in && ir_lvl_reg != 7'h00;

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	// Link phase sequencing.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg        <= ST_INIT;
			init_cnt_reg     <= 5'h00;
			pending_reg      <= 1'b0;
			pending_kind_reg <= RSP_NONE;
			conn_addr_reg    <= 8'h00;
			nego_rate_reg    <= IR_RATE_DEFAULT;
		end
		else
		begin
			if (resp_valid_out)
				pending_reg <= 1'b0;
			case (state_reg)
				ST_INIT:
				begin
					init_cnt_reg <= init_cnt_reg + 5'h01;
					if (init_cnt_reg == 5'(INIT_CYCLES - 1))
						state_reg <= ST_NDM; // RQ14
				end
				ST_NDM:
				begin
					if (good_frame && frame_kind_in == FR_XID && frame_slot_in == CLAIM_SLOT)
					begin
						pending_reg      <= 1'b1; // RQ8
						pending_kind_reg <= RSP_XID;
						state_reg        <= ST_CLAIMED;
					end
				end
				ST_CLAIMED:
				begin
					// Remaining polls get no answer; the broadcast id closes discovery.
					if (good_frame && frame_kind_in == FR_BCAST_ID)
						state_reg <= ST_DISCOVERY; // RQ9
				end
				ST_DISCOVERY:
				begin
					if (good_frame && frame_kind_in == FR_SNRM)
					begin
						conn_addr_reg    <= frame_addr_in; // RQ11
						nego_rate_reg    <= frame_rate_in; // RQ21
						pending_reg      <= 1'b1;
						pending_kind_reg <= RSP_UA_PARAMS;
						state_reg        <= ST_IAS;
					end
				end
				ST_IAS:
				begin
					if (good_frame && frame_kind_in == FR_OPEN_IAS)
					begin
						pending_reg      <= 1'b1; // RQ12
						pending_kind_reg <= RSP_CONFIRM_IAS;
					end
					else if (good_frame && frame_kind_in == FR_IAS_QUERY)
					begin
						pending_reg      <= 1'b1; // RQ12
						pending_kind_reg <= RSP_IAS_ANSWER;
					end
					else if (good_frame && frame_kind_in == FR_OPEN_DATA)
					begin
						pending_reg      <= 1'b1; // RQ12
						pending_kind_reg <= RSP_CONFIRM_DATA;
						state_reg        <= ST_NRM;
					end
					else if (idle_cnt_reg >= 40'(FALLBACK_CNT - 1))
						state_reg <= ST_NDM;
				end
				ST_NRM:
				begin
					if (good_frame && frame_kind_in == FR_DISC)
					begin
						pending_reg      <= 1'b1; // RQ6
						pending_kind_reg <= RSP_CONFIRM_CLOSE;
						state_reg        <= ST_NDM;
					end
					else if (good_frame)
					begin
						// Every good frame is answered, with data or a bare status frame.
						pending_reg      <= 1'b1; // RQ5
						pending_kind_reg <= RSP_DATA;
					end
					else if (idle_cnt_reg >= 40'(FALLBACK_CNT - 1))
						state_reg <= ST_NDM; // RQ7
				end
				default:
					state_reg <= ST_INIT;
			endcase
			// Only the phases before link setup forget the rate; setup itself captures it.
			if (state_reg == ST_NDM || state_reg == ST_CLAIMED)
				nego_rate_reg <= IR_RATE_DEFAULT; // RQ21
		end
	end

	// Inactivity timer; restarts on any received frame, good or not.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			idle_cnt_reg <= 40'h00_0000_0000;
		else if (frame_valid_in || (state_reg != ST_NRM && state_reg != ST_IAS))
			idle_cnt_reg <= 40'h00_0000_0000; // RQ7
		else if (idle_cnt_reg < 40'(FALLBACK_CNT))
			idle_cnt_reg <= idle_cnt_reg + 40'h00_0000_0001;
	end

	// Turnaround gap: the longer of the latency and one bit time since the last frame or receive activity.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			turn_cnt_reg <= 32'h0000_0000;
		else if (frame_valid_in || ir_rx_active_in)
			turn_cnt_reg <= 32'((TURNAROUND_CNT > BIT_TIME_CNT) ? TURNAROUND_CNT
				: BIT_TIME_CNT); // RQ19 RQ20
		else if (turn_cnt_reg != 32'h0000_0000)
			turn_cnt_reg <= turn_cnt_reg - 32'h0000_0001;
	end

	assign resp_valid_out = pending_reg && turn_cnt_reg == 32'h0000_0000
		&& !ir_rx_active_in && !ir_tx_active_in; // RQ19
	assign resp_kind_out  = pending_kind_reg;
	assign resp_addr_out  = conn_addr_reg; // RQ11

	// Data payload is capped at one block; protocol bytes are added by the framer.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			resp_len_out <= 7'h00;
		else if (ser_lvl_reg > 7'(BUF_DEPTH))
			resp_len_out <= 7'(BUF_DEPTH); // RQ18
		else
			resp_len_out <= ser_lvl_reg; // RQ18
	end

	// Rate switches only after the link-setup answer has gone out at the default rate.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			ir_rate_reg <= IR_RATE_DEFAULT; // RQ21
		else if (state_reg == ST_NDM || state_reg == ST_CLAIMED || state_reg == ST_DISCOVERY)
			ir_rate_reg <= IR_RATE_DEFAULT; // RQ21
		else if (tx_done_in && !pending_reg)
			ir_rate_reg <= nego_rate_reg; // RQ21
	end

	// Serial rate follows the select pins only; infrared rate is separate.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			uart_rate_out <= 2'h0;
		else
			uart_rate_out <= uart_rate_select_in; // RQ22
	end

	// An infrared packet holds the serial side off until the response is sent.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			ir_busy_reg <= 1'b0;
		else if (ir_rx_active_in)
			ir_busy_reg <= 1'b1; // RQ17
		else if (tx_done_in)
			ir_busy_reg <= 1'b0;
	end

	// Modem lines are made here; nothing of them travels over the link.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cts_n_reg <= 1'b1;
			cd_n_out  <= 1'b1;
			dsr_n_out <= 1'b1;
		end
		else
		begin
			cts_n_reg <= ir_side_busy; // RQ2 RQ15
			cd_n_out  <= !(state_reg == ST_NRM); // RQ13
			dsr_n_out <= state_reg == ST_INIT; // RQ14
		end
	end
	assign cts_n_out     = cts_n_reg;
	assign connected_out = state_reg == ST_NRM;

	// Bytes taken while clear-to-send is high count against the small UART FIFO.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fifo_cnt_reg <= 2'h0;
			drop_reg     <= 1'b0;
		end
		else
		begin
			drop_reg <= uart_byte_in && !ser_accept; // RQ3 RQ4
			if (!cts_n_reg)
				fifo_cnt_reg <= 2'h0;
			else if (uart_byte_in && ser_accept)
				fifo_cnt_reg <= fifo_cnt_reg + 2'h1; // RQ4
		end
	end
	assign uart_drop_out = drop_reg;

	// Serial-side buffer; drained when a data frame is answered.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ser_wr_reg  <= 6'h00;
			ser_lvl_reg <= 7'h00;
		end
		else if (resp_valid_out && pending_kind_reg == RSP_DATA)
			ser_lvl_reg <= 7'h00; // RQ18
		else if (ser_accept)
		begin
			ser_wr_reg  <= ser_wr_reg + 6'h01; // RQ16
			ser_lvl_reg <= ser_lvl_reg + 7'h01;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (ser_accept)
			ser_buf_mem[ser_wr_reg] <= uart_byte_data_in;
		if (ir_push)
			ir_buf_mem[ir_wr_reg] <= ir_byte_data_in;
	end

	// Infrared-side buffer toward the host.
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ir_wr_reg  <= 6'h00;
			ir_rd_reg  <= 6'h00;
			ir_lvl_reg <= 7'h00;
		end
		else
		begin
			if (ir_push)
				ir_wr_reg <= ir_wr_reg + 6'h01; // RQ16
			if (ir_pop)
				ir_rd_reg <= ir_rd_reg + 6'h01;
			ir_lvl_reg <= ir_lvl_reg + 7'(ir_push) - 7'(ir_pop);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			ir_buf_head_out <= 8'h00;
		else
			ir_buf_head_out <= ir_buf_mem[ir_pop ? ir_rd_reg + 6'h01 : ir_rd_reg];
	end

	assign ir_rate_out       = ir_rate_reg;
	assign ir_buf_level_out  = ir_lvl_reg;
	assign ser_buf_level_out = ser_lvl_reg;
endmodule : irsl_link_ctrl
`default_nettype wire

//--- irsl_link_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module irsl_link_ctrl_checker
	import irsl_pkg::*;
#(
	parameter longint FALLBACK_CNT   = 2000,
	parameter int     TURNAROUND_CNT = 20,
	parameter int     BIT_TIME_CNT   = 5
) (
	input wire logic                 ref_clk_in,
	input wire logic                 rst_n_in,
	input wire logic                 frame_valid_in,
	input wire logic                 ir_rx_active_in,
	input wire logic                 ir_tx_active_in,
	input wire logic                 uart_byte_in,
	input wire logic [1:0]           uart_rate_select_in,
	input wire logic                 tx_done_in,
	input wire logic                 resp_valid_out,
	input wire irsl_pkg::irsl_resp_t resp_kind_out,
	input wire logic [2:0]           ir_rate_out,
	input wire logic [1:0]           uart_rate_out,
	input wire logic                 cd_n_out,
	input wire logic                 dsr_n_out,
	input wire logic                 cts_n_out,
	input wire logic                 connected_out,
	input wire logic [6:0]           ir_buf_level_out,
	input wire logic [6:0]           ser_buf_level_out,
	input wire logic                 uart_drop_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic   [5:0] up_cnt;
	int           gap_cnt;
	longint       idle_cnt;
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
		if (!rst_n_in) up_cnt <= 6'h00;
		else if (up_cnt != 6'h3F) up_cnt <= up_cnt + 6'h01;
	// The gap restarts on any receive activity, not only on accepted frames.
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
		if (!rst_n_in) gap_cnt <= 0;
		else if (frame_valid_in || ir_rx_active_in) gap_cnt <= 0;
		else if (gap_cnt < 1000) gap_cnt <= gap_cnt + 1;
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
		if (!rst_n_in) idle_cnt <= 0;
		else if (frame_valid_in || !connected_out) idle_cnt <= 0;
		else idle_cnt <= idle_cnt + 1;
	a_cts_during_ir: assert property ((ir_rx_active_in || ir_tx_active_in) |=> cts_n_out)
		else $error("clear-to-send low during infrared traffic");
	a_cts_outside_data: assert property (!connected_out ##1 !connected_out |-> cts_n_out)
		else $error("clear-to-send low outside data mode");
	a_cd_in_data: assert property ($fell(cd_n_out) |-> connected_out)
		else $error("carrier detect fell outside data mode");
	a_cd_needs_dsr: assert property (!cd_n_out |-> !dsr_n_out)
		else $error("carrier detect low before ready");
	a_dsr_after_init: assert property (!dsr_n_out |-> up_cnt >= 6'h10)
		else $error("ready raised before initialisation ended");
	a_resp_one_pulse: assert property (resp_valid_out |=> !resp_valid_out)
		else $error("response request longer than one cycle");
	a_resp_after_gap: assert property (resp_valid_out |-> !ir_rx_active_in && gap_cnt >= TURNAROUND_CNT - 2)
		else $error("response sent before turnaround elapsed");
	a_ir_rate_hold: assert property ($changed(ir_rate_out) |-> $past(tx_done_in) || ir_rate_out == IR_RATE_DEFAULT)
		else $error("infrared rate changed without negotiation");
	a_rate_apart: assert property ($changed(uart_rate_select_in) |=> $stable(ir_rate_out) && uart_rate_out == $past(uart_rate_select_in))
		else $error("serial rate pins not followed or leaked");
	a_drop_cause: assert property (uart_drop_out |-> $past(uart_byte_in))
		else $error("drop flagged without a serial byte");
	a_buf_bound: assert property (ir_buf_level_out <= 7'h40 && ser_buf_level_out <= 7'h40)
		else $error("buffer level above 64");
	a_idle_fallback: assert property (connected_out |-> idle_cnt <= FALLBACK_CNT + 2)
		else $error("link kept after the idle limit");
	c_xid: cover property (resp_valid_out && resp_kind_out == RSP_XID);
	c_cd: cover property ($fell(cd_n_out));
	c_drop: cover property (uart_drop_out);
endmodule : irsl_link_ctrl_checker
bind irsl_link_ctrl irsl_link_ctrl_checker #(.FALLBACK_CNT(FALLBACK_CNT),
	.TURNAROUND_CNT(TURNAROUND_CNT), .BIT_TIME_CNT(BIT_TIME_CNT)) u_chk (.ref_clk_in,
	.rst_n_in, .frame_valid_in, .ir_rx_active_in, .ir_tx_active_in, .uart_byte_in,
	.uart_rate_select_in, .tx_done_in, .resp_valid_out, .resp_kind_out, .ir_rate_out,
	.uart_rate_out, .cd_n_out, .dsr_n_out, .cts_n_out, .connected_out, .ir_buf_level_out,
	.ser_buf_level_out, .uart_drop_out);
`default_nettype wire

//--- irsl_primary_model.sv
`timescale 1ns/1ps
`default_nettype none
module irsl_primary_model
	import irsl_pkg::*;
(
	input  wire logic            ref_clk_in,
	input  wire logic            resp_valid_in,
	output irsl_pkg::irsl_frame_t frame_kind_out,
	output logic                 frame_valid_out,
	output logic                 crc_ok_out,
	output logic [2:0]           slot_out,
	output logic [7:0]           addr_out,
	output logic [2:0]           rate_out,
	output logic                 rx_active_out,
	output logic                 tx_active_out,
	output logic                 tx_done_out
);
	logic [3:0] tx_cnt = 4'h0;
	initial
	begin
		{frame_valid_out, crc_ok_out, rx_active_out, tx_active_out, tx_done_out} = 5'h00;
		{slot_out, addr_out, rate_out} = 14'h0000;
		frame_kind_out = FR_NONE;
	end
	// Our own transmission keeps the optical path busy for a while after each response.
	always @(posedge ref_clk_in)
	begin
		tx_done_out <= 1'b0;
		if (resp_valid_in === 1'b1)
		begin
			tx_active_out <= 1'b1;
			tx_cnt <= 4'hB;
		end
		else if (tx_cnt == 4'h1)
		begin
			tx_active_out <= 1'b0;
			tx_done_out <= 1'b1;
			tx_cnt <= 4'h0;
		end
		else if (tx_cnt != 4'h0)
			tx_cnt <= tx_cnt - 4'h1;
	end
	task automatic send(input irsl_frame_t k, input logic [2:0] s, input logic [7:0] a,
		input logic [2:0] r, input logic c, input int pre);
		repeat (pre) @(posedge ref_clk_in) rx_active_out <= 1'b1;
		@(posedge ref_clk_in);
		frame_valid_out <= 1'b1;
		frame_kind_out <= k;
		{slot_out, addr_out, rate_out, crc_ok_out} <= {s, a, r, c};
		@(posedge ref_clk_in);
		// Released qualifiers must not keep a stale but plausible value.
		frame_valid_out <= 1'b0;
		rx_active_out <= 1'b0;
		frame_kind_out <= FR_NONE;
		{slot_out, addr_out, rate_out} <= ~{s, a, r};
		repeat (60) @(posedge ref_clk_in);
	endtask : send
endmodule : irsl_primary_model
`default_nettype wire

//--- tb_ir_secondary_link_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ir_secondary_link_control;
	import irsl_pkg::*;
	logic        clk, rst_n, ub, ib, pop, fv, crc, rxa, txa, td, rv, cd_n, dsr_n, cts_n, conn, drop;
	logic [7:0]  ud, id, fa, ra, head, addr, d0, d1;
	logic [2:0]  fs, fr, ir_rate, rate;
	logic [1:0]  rs, ur;
	logic [6:0]  rl, il, sl, dlen;
	irsl_frame_t fk;
	irsl_resp_t  rk;
	irsl_resp_t  exp_q[$];
	int          miscompares = 0, cmp_count = 0, drops = 0, n;
	irsl_link_ctrl #(.FALLBACK_CNT(2000), .TURNAROUND_CNT(20), .BIT_TIME_CNT(5)) dut (
		.ref_clk_in(clk), .rst_n_in(rst_n), .frame_valid_in(fv), .frame_kind_in(fk),
		.frame_crc_ok_in(crc), .frame_slot_in(fs), .frame_addr_in(fa), .frame_rate_in(fr),
		.ir_rx_active_in(rxa), .ir_tx_active_in(txa), .ir_byte_in(ib), .ir_byte_data_in(id),
		.ir_buf_pop_in(pop), .uart_byte_in(ub), .uart_byte_data_in(ud),
		.uart_rate_select_in(rs), .tx_done_in(td), .resp_valid_out(rv), .resp_kind_out(rk),
		.resp_addr_out(ra), .resp_len_out(rl), .ir_rate_out(ir_rate), .uart_rate_out(ur),
		.cd_n_out(cd_n), .dsr_n_out(dsr_n), .cts_n_out(cts_n), .connected_out(conn),
		.ir_buf_level_out(il), .ser_buf_level_out(sl), .ir_buf_head_out(head),
		.uart_drop_out(drop));
	irsl_primary_model pm (.ref_clk_in(clk), .resp_valid_in(rv), .frame_kind_out(fk),
		.frame_valid_out(fv), .crc_ok_out(crc), .slot_out(fs), .addr_out(fa), .rate_out(fr),
		.rx_active_out(rxa), .tx_active_out(txa), .tx_done_out(td));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	task automatic give_up(input logic hit);
		if (hit)
		begin
			miscompares++;
			test_done();
		end
	endtask : give_up
	task automatic frm(input irsl_frame_t k, input logic [2:0] s, input irsl_resp_t e);
		if (e != RSP_NONE)
			exp_q.push_back(e);
		pm.send(k, s, addr, rate, 1'b1, 3);
	endtask : frm
	task automatic pulse(input logic ir, input logic [7:0] d);
		@(posedge clk);
		{ib, ub, id, ud} <= {ir, !ir, d, d};
		@(posedge clk);
		{ib, ub} <= 2'h0;
		@(posedge clk);
	endtask : pulse
	task automatic connect();
		for (int s = 0; s < 8; s++)
			frm(FR_XID, 3'(s), s == 2 ? RSP_XID : RSP_NONE);
		frm(FR_BCAST_ID, 3'h0, RSP_NONE);
		frm(FR_SNRM, 3'h0, RSP_UA_PARAMS);
		chk(ra, addr);
		chk(8'(ir_rate), 8'(rate));
		frm(FR_OPEN_IAS, 3'h0, RSP_CONFIRM_IAS);
		frm(FR_IAS_QUERY, 3'h0, RSP_IAS_ANSWER);
		frm(FR_IAS_QUERY, 3'h0, RSP_IAS_ANSWER);
		frm(FR_OPEN_DATA, 3'h0, RSP_CONFIRM_DATA);
		chk({6'h00, cd_n, conn}, 8'h01);
	endtask : connect
	always @(posedge clk)
	begin
		if (drop === 1'b1)
			drops++;
		if (rv === 1'b1 && exp_q.size() == 0)
			chk(8'(rk), 8'hFF);
		else if (rv === 1'b1)
			chk(8'(rk), 8'(exp_q.pop_front()));
		// The length still holds the cycle after the request and clears one cycle later; it is taken while the request is raised.
		if (rv === 1'b1)
			dlen <= rl;
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		miscompares++;
		test_done();
	end
	initial
	begin
		void'($urandom(32'hDD442E8E));
		{rst_n, ub, ib, pop, ud, id, rs} = 22'h000000;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (n = 0; n < 100 && dsr_n !== 1'b0; n++)
			@(posedge clk);
		chk({6'h00, dsr_n, cts_n}, 8'h01);
		give_up(n == 100);
		addr = 8'($urandom);
		rate = 3'($urandom_range(7, 1));
		rs <= 2'($urandom);
		repeat (3) @(posedge clk);
		chk({6'h00, ur}, {6'h00, rs});
		chk(8'(ir_rate), 8'h00);
		pm.send(FR_XID, 3'h2, addr, rate, 1'b0, 3);
		connect();
		repeat (3) pulse(1'b0, 8'($urandom));
		chk({1'b0, sl}, 8'h03);
		frm(FR_DATA, 3'h0, RSP_DATA);
		chk({1'b0, dlen}, 8'h03);
		chk({1'b0, sl}, 8'h00);
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		pulse(1'b1, d0);
		pulse(1'b1, d1);
		chk({1'b0, il}, 8'h02);
		chk(head, d0);
		pop <= 1'b1;
		@(posedge clk);
		pop <= 1'b0;
		@(posedge clk);
		chk({1'b0, il}, 8'h01);
		chk(head, d1);
		exp_q.push_back(RSP_DATA);
		fork
			pm.send(FR_DATA, 3'h0, addr, rate, 1'b1, 12);
			begin
				for (n = 0; n < 20 && cts_n !== 1'b1; n++)
					@(posedge clk);
				give_up(n == 20);
				// Three bytes against a raised handshake: the third must be lost.
				repeat (3) pulse(1'b0, 8'($urandom));
			end
		join
		chk(8'(drops), 8'h01);
		frm(FR_DISC, 3'h0, RSP_CONFIRM_CLOSE);
		chk({6'h00, cd_n, conn}, 8'h02);
		connect();
		for (n = 0; n < 2100 && conn === 1'b1; n++)
			@(posedge clk);
		chk({7'h00, conn}, 8'h00);
		chk(8'(n > 1800), 8'h01);
		chk(8'(exp_q.size()), 8'h00);
		test_done();
	end
endmodule : tb_ir_secondary_link_control
`default_nettype wire
